// *** bench/lpddr2_device_model.sv ***
// eight-bank memory device model watching the host's command pins
// assumes memCk and cmd come from the host on clk; faults are counted, not fatal
`timescale 1ns/1ns
module lpddr2_device_model
  import lpddr2_refresh_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire cmd_t       cmd,
  input  wire logic       memCk,
  input  wire logic [7:0] bankOpen,
  input  wire logic       selfRefresh,
  output int              violations,
  output int              abCount,
  output int              pbCount,
  output int              actCount
);
  int         now;
  int         lastAb;
  int         lastPb;
  int         lastAct;
  int         abTimes[$];
  logic [2:0] pbBank;
  logic [2:0] bankCnt;
  logic [2:0] actBank;
  logic       ckPrev;

  task automatic flag(input string what);
    violations++;
    $display("unexpected %s at cycle %0d expected legal seen illegal", what, now);
  endtask : flag

  // sampled at the memory clock rise as seen from clk, as the device does
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      now = 0;
      lastAb = -1000;
      lastPb = -1000;
      lastAct = -1000;
      bankCnt = 3'h0;
      pbBank = 3'h0;
      ckPrev = 1'b0;
      abTimes.delete();
    end else begin
      now++;
      if (memCk && !ckPrev && !cmd.csN) begin
        if (selfRefresh) flag("command in self refresh");
        if (cmd.ca[2:0] == CA_REF) begin
          if (now - lastAb < CYC_RFCAB || now - lastPb < CYC_RFCPB) flag("refresh spacing");
          if (cmd.ca[REF_SCOPE_BIT]) begin
            if (bankOpen != 8'h00) flag("all-bank refresh with open row");
            while (abTimes.size() > 0 && now - abTimes[0] >= CYC_REFBW) void'(abTimes.pop_front());
            abTimes.push_back(now);
            if (abTimes.size() > BURST_MAX) flag("burst refresh cap");
            bankCnt = 3'h0;
            lastAb = now;
            abCount++;
          end else begin
            if (now - lastAct < CYC_RRD || bankOpen[bankCnt]) flag("per-bank refresh target");
            pbBank = bankCnt;
            bankCnt++;
            lastPb = now;
            pbCount++;
          end
        end else if (cmd.ca[1:0] == CA_ACT) begin
          actBank = cmd.ca[ACT_BANK_LSB +: 3];
          if (now - lastAb < CYC_RFCAB || now - lastAct < CYC_RRD || now - lastPb < CYC_RRD ||
              (now - lastPb < CYC_RFCPB && actBank == pbBank)) flag("activate spacing");
          lastAct = now;
          actCount++;
        end
      end
      ckPrev = memCk;
    end
  end
endmodule : lpddr2_device_model

// *** bench/tb_lpddr2_refresh_host.sv ***
// self-checking bench for the refresh scheduling host
// assumes the device model flags spacing faults and counts commands
`timescale 1ns/1ns
module tb_lpddr2_refresh_host;
  import lpddr2_refresh_pkg::*;
  localparam int REFW = 8000;
  localparam int REQ  = 8;
  logic       clk          = 1'b0;
  logic       rst_n        = 1'b0;
  act_req_t   actReq       = '0;
  logic [7:0] bankOpen     = 8'h00;
  logic       perBankEn    = 1'b0;
  logic       burstPattern = 1'b0;
  logic       selfRefresh  = 1'b0;
  logic       memCk;
  cmd_t       cmd;
  logic       actGrant;
  logic [2:0] pbTarget;
  logic       srSafe;
  logic       refreshShort;
  int         violations;
  int         abCount;
  int         pbCount;
  int         actCount;
  int         num_errors   = 0;
  int         checks       = 0;

  always #5 clk = ~clk;

  // short window and count keep the run brief
  lpddr2_refresh_host #(.CYC_REFW(REFW), .REQ_REFRESH(REQ), .NUM_BANKS(8), .CK_HALF(4)) u_lpddr2_refresh_host (
    .clk(clk), .rst_n(rst_n), .actReq(actReq), .bankOpen(bankOpen), .perBankEn(perBankEn),
    .burstPattern(burstPattern), .selfRefresh(selfRefresh), .memCk(memCk), .cmd(cmd),
    .actGrant(actGrant), .pbTarget(pbTarget), .srSafe(srSafe), .refreshShort(refreshShort));
  lpddr2_device_model u_lpddr2_device_model (
    .clk(clk), .rst_n(rst_n), .cmd(cmd), .memCk(memCk), .bankOpen(bankOpen), .selfRefresh(selfRefresh),
    .violations(violations), .abCount(abCount), .pbCount(pbCount), .actCount(actCount));

  function automatic int refs();
    return abCount + pbCount / 8;
  endfunction : refs

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    num_errors = num_errors + violations;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic timeout();
    num_errors++;
    $display("unexpected wait length expected done seen timeout");
    conclude();
  endtask : timeout

  // waits for the model to count the next per-bank (onPb) or all-bank refresh
  task automatic waitChange(input bit onPb);
    int s;
    s = onPb ? pbCount : abCount;
    for (int i = 0; i < 3000 && (onPb ? pbCount : abCount) == s; i++) @(posedge clk) #1;
    if ((onPb ? pbCount : abCount) == s) timeout();
  endtask : waitChange

  task automatic resetTest();
    repeat (2) @(posedge clk);
    #1 chk("reset outputs", 16'h0021, {memCk, actGrant, srSafe, refreshShort, pbTarget, cmd.csN});
    @(posedge clk) rst_n <= 1'b1;
    @(posedge clk) #1 chk("released outputs", 16'h0021, {memCk, actGrant, srSafe, refreshShort, pbTarget, cmd.csN});
    chk("idle ca", 10'h3ff, cmd.ca);
  endtask : resetTest

  task automatic distributed();
    int s;
    s = refs();
    repeat (REFW) @(posedge clk);
    #1 chk("window count met", 1, refs() - s >= REQ);
    chk("one per interval", 1, refs() - s <= REFW / CYC_REFI + 1);
    chk("sr safe distributed", 1, srSafe);
  endtask : distributed

  task automatic activate(input logic [2:0] b);
    int i;
    @(posedge clk) actReq <= '{valid: 1'b1, bank: b};
    for (i = 0; i < 3000; i++) begin
      @(posedge clk) #1;
      if (actGrant === 1'b1) break;
    end
    if (i == 3000) timeout();
    chk("act ca", {b, 7'h02}, cmd.ca);
    chk("act cs", 0, cmd.csN);
    @(posedge clk) actReq <= '0;
    bankOpen[b] <= 1'b1;
    #1 chk("grant pulse", 0, actGrant);
  endtask : activate

  task automatic perBank();
    int s;
    @(posedge clk) perBankEn <= 1'b1;
    // bank two held open: its turn must wait
    bankOpen <= 8'h04;
    repeat (600) @(posedge clk);
    bankOpen <= 8'h00;
    s = pbCount;
    repeat (1200) @(posedge clk);
    #1 chk("per-bank progress", 1, pbCount - s >= 8);
    waitChange(1'b1);
    chk("pb target", u_lpddr2_device_model.bankCnt, pbTarget);
    @(posedge clk) perBankEn <= 1'b0;
    waitChange(1'b0);
    chk("target cleared", 0, pbTarget);
  endtask : perBank

  task automatic burstPause();
    int s;
    s = refs();
    @(posedge clk) burstPattern <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("sr unsafe in burst", 0, srSafe);
    repeat (998) @(posedge clk);
    #1 chk("sr safe after burst", 1, srSafe);
    @(posedge clk) selfRefresh <= 1'b1;
    repeat (3000) @(posedge clk);
    selfRefresh <= 1'b0;
    // leaving the pattern during the pause phase
    burstPattern <= 1'b0;
    repeat (2 * REFW) @(posedge clk);
    #1 chk("no short window", 0, refreshShort);
    chk("refreshes issued", 1, refs() - s >= REQ);
  endtask : burstPause

  task automatic shortWindow();
    int i;
    // open banks just after a refresh so none is in flight when they close off
    waitChange(1'b0);
    @(posedge clk) bankOpen <= 8'hff;
    for (i = 0; i < 2 * REFW + 100 && refreshShort !== 1'b1; i++) @(posedge clk) #1;
    chk("short flagged", 1, refreshShort);
    @(posedge clk) bankOpen <= 8'h00;
  endtask : shortWindow

  initial begin
    resetTest();
    distributed();
    activate(3'h3);
    activate(3'h5);
    repeat (40) @(posedge clk);
    bankOpen <= 8'h00;
    #1 chk("activates seen", 2, actCount);
    perBank();
    burstPause();
    shortWindow();
    conclude();
  end
endmodule : tb_lpddr2_refresh_host

// *** hw/lpddr2_refresh_host.sv ***
// refresh and activate scheduler driving the memory command pins
// assumes bankOpen and actReq come from logic on clk; the memory clock is made here
`timescale 1ns/1ns
// How it works
// - after all-bank refresh, wait its cycle time before any refresh or activate
// - after per-bank refresh, wait its cycle time before refreshes or same-bank activate
// - activate to another bank waits the activate-to-activate delay after per-bank refresh
// - per-bank refresh of an idle bank waits activate-to-activate delay after activate
// - activates to different banks are spaced by the activate-to-activate delay
// - all-bank refresh only with every bank idle; per-bank only to an idle bank
// - each refresh window must receive the required count of refreshes
// - eight per-bank refreshes count as one all-bank refresh
// - at most eight all-bank refreshes in any burst refresh window
// - self refresh time credits round-up of time over average interval
// - distributed pattern issues one refresh per average interval
// - switches out of the burst pattern are made right after a burst phase
// - never start distributed pattern directly after a pause phase
// - self refresh is safe only after burst phase or in distributed pattern
// - refresh: chip select low, bits 2..0 = 100, bit 3 selects scope
// - round-robin per-bank target counter, cleared by all-bank refresh
module lpddr2_refresh_host
  import lpddr2_refresh_pkg::*;
#(
  parameter int CYC_REFW    = CYC_REFW_DEF,
  parameter int REQ_REFRESH = REQ_DEF,
  parameter int NUM_BANKS   = 8,
  parameter int CK_HALF     = CK_HALF_DEF
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire act_req_t   actReq,
  input  wire logic [7:0] bankOpen,
  input  wire logic       perBankEn,
  input  wire logic       burstPattern,
  input  wire logic       selfRefresh,
  output logic            memCk,
  output cmd_t            cmd,
  output logic            actGrant,
  output logic [2:0]      pbTarget,
  output logic            srSafe,
  output logic            refreshShort
);
  logic [7:0]  divCnt_reg;
  logic [15:0] abWait_reg, pbWait_reg, rrdWait_reg, refiCnt_reg, srTick_reg;
  logic [15:0] burstT_reg [BURST_MAX];
  logic [31:0] winCnt_reg, unitCnt_reg, srCredit_reg;
  logic [3:0]  owed_reg;
  logic [2:0]  lastPb_reg;
  logic        srPrev_reg;
  pattern_t    state_reg;
  logic        slot, usePb, burstFree, refWant, abOk, pbOk, actOk, doAb, doPb, doAct;
  logic        refiTick, winEnd;
  logic [2:0]  freeIdx;
  logic [31:0] need;
  logic [15:0] refiLim;
  // per-bank scope only on eight-bank parts
  assign usePb   = perBankEn && (NUM_BANKS == 8);
  // commands change at the falling edge so the rising edge sees them settled
  assign slot    = memCk && (divCnt_reg == 8'(CK_HALF - 1));
  assign refiLim = usePb ? 16'(CYC_REFI / PB_PER_AB) : 16'(CYC_REFI);
  // switching to the shorter per-bank interval can leave the count past its limit
  assign refiTick = (refiCnt_reg >= refiLim - 16'h0001);
  assign winEnd  = (winCnt_reg == 32'(CYC_REFW - 1));
  // self refresh credit lowers the count still required
  assign need    = (srCredit_reg >= 32'(REQ_REFRESH)) ? 32'h0 : 32'(REQ_REFRESH) - srCredit_reg;
  // a free slot among the eight burst timers
  always_comb begin
    burstFree = 1'b0;
    freeIdx   = 3'h0;
    for (int i = BURST_MAX - 1; i >= 0; i--) begin
      if (burstT_reg[i] == 16'h0) begin
        burstFree = 1'b1;
        freeIdx   = 3'(i);
      end
    end
  end
  // each spacing timer gates the commands it governs
  always_comb begin
    refWant = !selfRefresh && ((state_reg == PAT_BURST && unitCnt_reg < need)
                               || (state_reg == PAT_DIST && owed_reg != 4'h0));
    // all banks idle and both refresh cycle times over
    abOk = abWait_reg == 16'h0 && pbWait_reg == 16'h0 && bankOpen == 8'h0 && burstFree;
    // target bank idle and activate spacing over
    pbOk = abWait_reg == 16'h0 && pbWait_reg == 16'h0 && rrdWait_reg == 16'h0
           && !bankOpen[pbTarget];
    // other bank waits activate spacing, same bank the per-bank cycle
    actOk = actReq.valid && !selfRefresh && abWait_reg == 16'h0 && rrdWait_reg == 16'h0
            && !(pbWait_reg != 16'h0 && actReq.bank == lastPb_reg);
    doAb  = slot && refWant && !usePb && abOk;
    doPb  = slot && refWant && usePb && pbOk;
    // burst phase owns the bus; distributed refresh yields only while blocked
    doAct = slot && actOk && !doAb && !doPb && !(refWant && state_reg == PAT_BURST);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_reg <= 8'h0;
      memCk      <= 1'b0;
    end else if (divCnt_reg == 8'(CK_HALF - 1)) begin
      divCnt_reg <= 8'h0;
      memCk      <= !memCk;
    end else begin
      divCnt_reg <= divCnt_reg + 8'h01;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd      <= CMD_DESEL;
      actGrant <= 1'b0;
    end else begin
      actGrant <= doAct;
      if (doAb || doPb) begin
        cmd.csN              <= 1'b0;
        cmd.ca               <= 10'h3f0;
        cmd.ca[2:0]          <= CA_REF;
        cmd.ca[REF_SCOPE_BIT] <= doAb;
      end else if (doAct) begin
        cmd.csN     <= 1'b0;
        cmd.ca      <= {actReq.bank, 5'h00, 2'h0};
        cmd.ca[1:0] <= CA_ACT;
      end else if (slot) begin
        cmd <= CMD_DESEL;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      abWait_reg  <= 16'h0;
      pbWait_reg  <= 16'h0;
      rrdWait_reg <= 16'h0;
      lastPb_reg  <= 3'h0;
    end else begin
      abWait_reg  <= doAb ? 16'(CYC_RFCAB - 1) : (abWait_reg != 16'h0 ? abWait_reg - 16'h0001 : 16'h0);
      pbWait_reg  <= doPb ? 16'(CYC_RFCPB - 1) : (pbWait_reg != 16'h0 ? pbWait_reg - 16'h0001 : 16'h0);
      rrdWait_reg <= (doPb || doAct) ? 16'(CYC_RRD - 1)
                     : (rrdWait_reg != 16'h0 ? rrdWait_reg - 16'h0001 : 16'h0);
      if (doPb) begin
        lastPb_reg <= pbTarget;
      end
    end
  end
  // one timer per all-bank refresh in the burst window
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < BURST_MAX; i++) begin
        burstT_reg[i] <= 16'h0;
      end
    end else begin
      for (int i = 0; i < BURST_MAX; i++) begin
        if (doAb && freeIdx == 3'(i)) begin
          burstT_reg[i] <= 16'(CYC_REFBW - 1);
        end else if (burstT_reg[i] != 16'h0) begin
          burstT_reg[i] <= burstT_reg[i] - 16'h0001;
        end
      end
    end
  end
  // round-robin target, cleared by all-bank refresh
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pbTarget <= 3'h0;
    end else if (doAb) begin
      pbTarget <= 3'h0;
    end else if (doPb) begin
      pbTarget <= pbTarget + 3'h1;
    end
  end
  // distributed pattern owes one refresh per interval
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refiCnt_reg <= 16'h0;
      owed_reg    <= 4'h0;
    end else begin
      refiCnt_reg <= refiTick ? 16'h0 : refiCnt_reg + 16'h0001;
      if (state_reg != PAT_DIST) begin
        owed_reg <= 4'h0;
      end else if (refiTick && !(doAb || doPb) && owed_reg != 4'(PB_PER_AB)) begin
        owed_reg <= owed_reg + 4'h1;
      end else if (!refiTick && (doAb || doPb)) begin
        owed_reg <= owed_reg - 4'h1;
      end
    end
  end
  // window count in all-bank units; short window is sticky
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      winCnt_reg   <= 32'h0;
      unitCnt_reg  <= 32'h0;
      refreshShort <= 1'b0;
    end else begin
      winCnt_reg <= winEnd ? 32'h0 : winCnt_reg + 32'h1;
      if (winEnd) begin
        unitCnt_reg <= 32'h0;
        if (unitCnt_reg < need) begin
          refreshShort <= 1'b1;
        end
      end else if (doAb || (doPb && pbTarget == 3'(PB_PER_AB - 1))) begin
        unitCnt_reg <= unitCnt_reg + 32'h1;
      end
    end
  end
  // credit one on entry and one per further interval, i.e. round-up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      srPrev_reg   <= 1'b0;
      srTick_reg   <= 16'h0;
      srCredit_reg <= 32'h0;
    end else begin
      srPrev_reg <= selfRefresh;
      srTick_reg <= (!selfRefresh || srTick_reg == 16'(CYC_REFI - 1)) ? 16'h0 : srTick_reg + 16'h0001;
      if (winEnd) begin
        srCredit_reg <= 32'h0;
      end else if (selfRefresh && (!srPrev_reg || srTick_reg == 16'(CYC_REFI - 1))) begin
        srCredit_reg <= srCredit_reg + 32'h1;
      end
    end
  end
  // leaves burst only at the end of a burst; distributed enters burst at once; pause always resumes in burst
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= PAT_DIST;
    end else begin
      unique case (state_reg)
        PAT_DIST:  if (burstPattern) state_reg <= PAT_BURST;
        PAT_BURST: if (unitCnt_reg >= need) state_reg <= burstPattern ? PAT_PAUSE : PAT_DIST;
        PAT_PAUSE: if (winEnd) state_reg <= PAT_BURST;
      endcase
    end
  end
  // self refresh safe in distributed pattern or right after a burst
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      srSafe <= 1'b1;
    end else begin
      srSafe <= state_reg != PAT_BURST;
    end
  end
  // helper counters of cycles since each command, for the checks below
  logic [15:0] sinceAb, sincePb, sinceAct;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sinceAb  <= 16'hffff;
      sincePb  <= 16'hffff;
      sinceAct <= 16'hffff;
    end else begin
      sinceAb  <= doAb ? 16'h0 : (sinceAb == 16'hffff ? sinceAb : sinceAb + 16'h0001);
      sincePb  <= doPb ? 16'h0 : (sincePb == 16'hffff ? sincePb : sincePb + 16'h0001);
      sinceAct <= doAct ? 16'h0 : (sinceAct == 16'hffff ? sinceAct : sinceAct + 16'h0001);
    end
  end
  a_ab_spacing: assert property (@(posedge clk) disable iff (!rst_n)
    (doAb || doPb || doAct) |-> sinceAb >= 16'(CYC_RFCAB - 1))
    else $error("command inside all-bank refresh cycle time");
  a_pb_spacing: assert property (@(posedge clk) disable iff (!rst_n)
    (doAb || doPb || (doAct && actReq.bank == lastPb_reg)) |-> sincePb >= 16'(CYC_RFCPB - 1))
    else $error("command inside per-bank refresh cycle time");
  a_act_after_pb: assert property (@(posedge clk) disable iff (!rst_n)
    doAct |-> sincePb >= 16'(CYC_RRD - 1))
    else $error("activate too soon after per-bank refresh");
  a_pb_after_act: assert property (@(posedge clk) disable iff (!rst_n)
    doPb |-> sinceAct >= 16'(CYC_RRD - 1))
    else $error("per-bank refresh too soon after activate");
  a_act_spacing: assert property (@(posedge clk) disable iff (!rst_n)
    doAct |=> !doAct [*2])
    else $error("activates too close");
  a_idle_banks: assert property (@(posedge clk) disable iff (!rst_n)
    (doAb |-> bankOpen == 8'h0) and (doPb |-> !bankOpen[pbTarget]))
    else $error("refresh to a bank with an open row");
  a_ref_encoding: assert property (@(posedge clk) disable iff (!rst_n)
    (doAb || doPb) |=> !cmd.csN && cmd.ca[2:0] == CA_REF && cmd.ca[REF_SCOPE_BIT] == $past(doAb))
    else $error("refresh encoding wrong");
  a_pb_only_8: assert property (@(posedge clk) disable iff (!rst_n)
    doPb |-> usePb)
    else $error("per-bank refresh on a four-bank part");
  a_target_clear: assert property (@(posedge clk) disable iff (!rst_n)
    doAb |=> pbTarget == 3'h0)
    else $error("all-bank refresh did not clear target");
  a_target_step: assert property (@(posedge clk) disable iff (!rst_n)
    doPb |=> pbTarget == $past(pbTarget) + 3'h1)
    else $error("per-bank target did not advance");
  a_no_pause_dist: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == PAT_PAUSE |=> state_reg != PAT_DIST)
    else $error("distributed pattern entered from pause");
  a_burst_free: assert property (@(posedge clk) disable iff (!rst_n)
    doAb |-> burstT_reg[freeIdx] == 16'h0)
    else $error("ninth all-bank refresh in burst window");
  c_all_bank: cover property (@(posedge clk) disable iff (!rst_n) doAb);
  c_per_bank_wrap: cover property (@(posedge clk) disable iff (!rst_n) doPb && pbTarget == 3'h7);
  c_activate: cover property (@(posedge clk) disable iff (!rst_n) doAct);
  c_burst_pause: cover property (@(posedge clk) disable iff (!rst_n)
    state_reg == PAT_BURST ##1 state_reg == PAT_PAUSE);
endmodule : lpddr2_refresh_host

// *** hw/lpddr2_refresh_pkg.sv ***
// constants and types for the refresh scheduling host
// assumes a 100 MHz system clock and an eight-bank memory by default
package lpddr2_refresh_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_RFCAB_NS    = 130;
  localparam int T_RFCPB_NS    = 60;
  localparam int T_RRD_NS      = 10;
  localparam int T_REFI_NS     = 7800;
  localparam int T_REFW_MS     = 32;
  // least times round up, the average interval rounds down
  localparam int CYC_RFCAB     = (T_RFCAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_RFCPB     = (T_RFCPB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_RRD       = (T_RRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_REFI      = T_REFI_NS / CLK_PERIOD_NS;
  localparam int BURST_MAX     = 8;
  localparam int PB_PER_AB     = 8;
  localparam int CYC_REFBW     = 4 * 8 * CYC_RFCAB;
  localparam int CYC_REFW_DEF  = T_REFW_MS * 1000000 / CLK_PERIOD_NS;
  localparam int REQ_DEF       = 4096;
  localparam int CK_HALF_DEF   = 4;
  localparam int REF_SCOPE_BIT = 3;
  localparam logic [2:0] CA_REF = 3'h4;
  localparam logic [1:0] CA_ACT = 2'h2;
  localparam int ACT_BANK_LSB  = 7;
  localparam logic [2:0] MR4_TEMP_RATE_1X = 3'h3;

  typedef struct packed {
    logic       csN;
    logic [9:0] ca;
  } cmd_t;

  localparam cmd_t CMD_DESEL = '{csN: 1'b1, ca: 10'h3ff};

  typedef struct packed {
    logic       valid;
    logic [2:0] bank;
  } act_req_t;

  typedef enum {PAT_DIST, PAT_BURST, PAT_PAUSE} pattern_t;
endpackage : lpddr2_refresh_pkg
